// >>> hdl/tpdp_phy.sv
// Digital core of a two-port data-strobe cable PHY with automatic low-power control.
// Assumes analog drivers, bias and comparators outside; link layer core on ref_clk.
//
// Summary of operation
// - Line bit timing derives from the one reference clock by dividing it.
// - The link layer core is clocked by the same system clock as this core.
// - Link bytes are latched, serialised and data-strobe coded at S100/S200/S400.
// - Transmit puts data on pair B and strobe on pair A of each port.
// - A receiving port has both transmitters off and its receivers on.
// - Received bits are decoded, resynchronised and handed to the link layer.
// - Received data is repeated on every other active port.
// - Incoming pair A common-mode level picks the next transmit speed.
// - Host power is full power or one of two reduced states, nothing else.
// - Reduced host power with all ports inactive enters low-power mode.
// - Low-power mode stops clock generators; keeps only needed detect references.
// - Deepest sleep only when ports disconnected or disabled and interrupts off.
// - Setting the link power status bit wakes the device from low power.
// - Port events needing a response or report also wake the device.
// - After wake, the system clock runs next cycle and PHY works WAKE_COUNT+1 cycles later (2 ms plus one cycle).
module tpdp_phy #(
  parameter int WAKE_COUNT = tpdp_pkg::WAKE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Link layer core transmit side
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire tpdp_pkg::tpdp_speed_e tx_speed,
  output logic tx_ready,
  // Link layer core receive side
  output logic rx_valid,
  output logic [7:0] rx_data,
  output tpdp_pkg::tpdp_speed_e next_speed,
  // Cable pair A per port
  input wire logic [1:0] cable_pair_a_in,
  output logic [1:0] cable_pair_a_out,
  output logic [1:0] cable_pair_a_oe,
  // Cable pair B per port
  input wire logic [1:0] cable_pair_b_in,
  output logic [1:0] cable_pair_b_out,
  output logic [1:0] cable_pair_b_oe,
  // Port condition and comparators
  input wire logic [1:0] port_receiving,
  input wire logic [1:0] port_connected,
  input wire logic [1:0] port_disabled,
  input wire logic [1:0] port_suspended,
  input wire logic [1:0] bias_detect,
  input wire logic [1:0] speed_sense,
  // Power management
  input wire tpdp_pkg::tpdp_host_e host_state,
  input wire logic link_power_status_bit,
  input wire logic port_int_enable,
  output logic clock_gen_enable,
  output logic sleep_deep,
  output logic phy_operative,
  output logic cable_bias_output_en,
  output logic [1:0] port_event
);
  import tpdp_pkg::*;

  typedef struct packed {
    logic [2:0][1:0] sa;
    logic [2:0][1:0] sb;
    logic [2:0][1:0] sbias;
    logic [2:0][1:0] sconn;
    logic [2:0][1:0] scm;
    logic [1:0] conn_q;
    logic [1:0] bias_q;
    tpdp_pwr_e pwr;
    logic [31:0] wake_cnt;
    logic [1:0] evt_pend;
    logic [1:0] evt_out;
    logic [3:0] div;
    logic [2:0] bitn;
    logic [7:0] sh;
    logic busy;
    logic tx_d;
    logic tx_s;
    logic [1:0] tx_en;
    tpdp_speed_e spd;
    tpdp_speed_e nspd;
    logic rx_v;
    logic [7:0] rx_d;
    logic take;
    logic cg_en;
    logic deep;
    logic oper;
    logic bias_en;
  } tpdp_phy_s;

  tpdp_phy_s st, next_st;
  logic fifo_ready, fifo_valid;
  logic [7:0] fifo_data;
  logic [1:0] rxb_valid;
  logic [7:0] rxb_data [NPORTS];
  logic [1:0] agree_a, agree_b, agree_bias, agree_conn, agree_cm;
  logic [1:0] inactive, ev_now;
  logic repeating;
  logic [7:0] rep_data;

  // Settled pin levels: second and third stages agree
  assign agree_a = ~(st.sa[1] ^ st.sa[2]);
  assign agree_b = ~(st.sb[1] ^ st.sb[2]);
  assign agree_bias = ~(st.sbias[1] ^ st.sbias[2]);
  assign agree_conn = ~(st.sconn[1] ^ st.sconn[2]);
  assign agree_cm = ~(st.scm[1] ^ st.scm[2]);

  // Link bytes pass through the FIFO before serialising
  tpdp_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(tx_valid),
    .in_data(tx_data),
    .in_ready(fifo_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(st.take)
  );

  // One decoder per port; data on pair A, strobe on pair B
  for (genvar p = 0; p < NPORTS; p++) begin : g_rx
    tpdp_ds_rx u_rx (
      .ref_clk(ref_clk),
      .reset(reset),
      .line_data(st.sa[2][p]),
      .line_strobe(st.sb[2][p]),
      .enable(port_receiving[p] && st.pwr == TPDP_PWR_ON),
      .byte_valid(rxb_valid[p]),
      .byte_data(rxb_data[p])
    );
  end

  // Port inactivity and wake-worthy events
  always_comb begin
    for (int p = 0; p < NPORTS; p++) begin
      inactive[p] = !port_connected[p] || port_disabled[p] || port_suspended[p];
      ev_now[p] = 1'b0;
      if (agree_bias[p] && port_suspended[p] && st.sbias[2][p] && !st.bias_q[p]) begin
        ev_now[p] = 1'b1;
      end
      if (agree_conn[p] && port_suspended[p] && !st.sconn[2][p] && st.conn_q[p]) begin
        ev_now[p] = 1'b1;
      end
      if (agree_conn[p] && !port_disabled[p] && st.sconn[2][p] && !st.conn_q[p]) begin
        ev_now[p] = 1'b1;
      end
    end
  end

  // Repeat whichever port is receiving onto the others
  assign repeating = |port_receiving;
  assign rep_data = rxb_valid[1] ? rxb_data[1] : rxb_data[0];

  always_comb begin
    next_st = st;
    // Three-stage pin synchronisers
    next_st.sa = {st.sa[1:0], cable_pair_a_in};
    next_st.sb = {st.sb[1:0], cable_pair_b_in};
    next_st.sbias = {st.sbias[1:0], bias_detect};
    next_st.sconn = {st.sconn[1:0], port_connected};
    next_st.scm = {st.scm[1:0], speed_sense};
    for (int p = 0; p < NPORTS; p++) begin
      if (agree_conn[p]) begin
        next_st.conn_q[p] = st.sconn[2][p];
      end
      if (agree_bias[p]) begin
        next_st.bias_q[p] = st.sbias[2][p];
      end
    end

    // Common-mode on pair A sets the next speed
    if (agree_cm[0] && agree_cm[1]) begin
      next_st.nspd = (st.scm[2] == 2'b11) ? TPDP_S400 :
                     (st.scm[2] != 2'b00) ? TPDP_S200 : TPDP_S100;
    end

    // Power state machine
    next_st.evt_out = '0;
    next_st.evt_pend = st.evt_pend | ev_now;
    case (st.pwr)
      TPDP_PWR_ON: begin
        // Held up while the link asks for power or a report is owed
        if (host_state != TPDP_HOST_D0 && &inactive && !st.busy && !repeating &&
            !link_power_status_bit && st.evt_pend == '0) begin
          // Deepest level only with no live cable and interrupts off
          if (&(~port_connected | port_disabled) && !port_int_enable) begin
            next_st.pwr = TPDP_PWR_SLEEP;
          end else begin
            next_st.pwr = TPDP_PWR_LOW;
          end
        end
        // Pending events go to the link once back in TPDP_PWR_ON
        next_st.evt_out = st.evt_pend;
        next_st.evt_pend = ev_now;
      end
      TPDP_PWR_LOW, TPDP_PWR_SLEEP: begin
        if (link_power_status_bit || |ev_now) begin
          next_st.pwr = TPDP_PWR_WAKE;
          next_st.wake_cnt = '0;
        end
      end
      TPDP_PWR_WAKE: begin
        // Bounded restart time: WAKE_COUNT cycles, equal to the whole 2 ms limit by default
        next_st.wake_cnt = st.wake_cnt + 1'b1;
        if (st.wake_cnt >= 32'(WAKE_COUNT - 1)) begin
          next_st.pwr = TPDP_PWR_ON;
        end
      end
      default: next_st.pwr = TPDP_PWR_ON;
    endcase

    // Received bytes resynchronised to ref_clk for the link
    next_st.rx_v = |rxb_valid;
    next_st.rx_d = rep_data;

    // Serialiser with divider per line rate
    next_st.take = 1'b0;
    if (st.pwr != TPDP_PWR_ON) begin
      next_st.busy = 1'b0;
      next_st.tx_en = '0;
    end else if (!st.busy) begin
      if (repeating) begin
        // Repeat at the arbitrated speed; a byte landing mid-send is lost
        if (|rxb_valid) begin
          next_st.sh = rep_data;
          next_st.spd = st.nspd;
          next_st.div = tpdp_div(st.nspd);
          next_st.bitn = '0;
          next_st.busy = 1'b1;
        end
      end else if (fifo_valid && !st.take) begin
        next_st.take = 1'b1;
        next_st.sh = fifo_data;
        next_st.spd = tx_speed;
        next_st.div = tpdp_div(tx_speed);
        next_st.bitn = '0;
        next_st.busy = 1'b1;
      end
      next_st.tx_en = '0;
    end else begin
      next_st.tx_en = ~port_receiving & port_connected & ~port_disabled;
      if (st.div == 4'h1) begin
        next_st.div = tpdp_div(st.spd);
        // Strobe toggles when data repeats, so one of them changes each bit
        next_st.tx_d = st.sh[7];
        next_st.tx_s = (st.sh[7] == st.tx_d) ? ~st.tx_s : st.tx_s;
        next_st.sh = {st.sh[6:0], 1'b0};
        next_st.bitn = st.bitn + 1'b1;
        if (st.bitn == BIT_LAST) begin
          next_st.busy = 1'b0;
        end
      end else begin
        next_st.div = st.div - 1'b1;
      end
    end

    // Power flags taken from the next level, so they track it cycle for cycle
    next_st.cg_en = (next_st.pwr == TPDP_PWR_ON) || (next_st.pwr == TPDP_PWR_WAKE);
    next_st.deep = (next_st.pwr == TPDP_PWR_SLEEP);
    next_st.oper = (next_st.pwr == TPDP_PWR_ON);
    next_st.bias_en = (next_st.pwr != TPDP_PWR_SLEEP);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      // Powered-on flags read high while reset holds
      st.cg_en <= 1'b1;
      st.oper <= 1'b1;
      st.bias_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs from flip-flops; pair B data, pair A strobe, repeat shares the serialiser
  assign tx_ready = fifo_ready;
  assign rx_valid = st.rx_v;
  assign rx_data = st.rx_d;
  assign next_speed = st.nspd;
  assign cable_pair_b_out = {2{st.tx_d}};
  assign cable_pair_a_out = {2{st.tx_s}};
  assign cable_pair_a_oe = st.tx_en;
  assign cable_pair_b_oe = st.tx_en;
  // Clock generators stop in both low levels
  assign clock_gen_enable = st.cg_en;
  assign sleep_deep = st.deep;
  assign phy_operative = st.oper;
  assign cable_bias_output_en = st.bias_en;
  assign port_event = st.evt_out;

endmodule

// >>> hdl/tpdp_pkg.sv
// Shared constants and types for the two-port data-strobe cable PHY digital core.
// Assumes one 125 MHz system clock (8 ns) and an active-high asynchronous reset.
package tpdp_pkg;

  // Clock and wake timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int WAKE_TIME_US = 2000;
  localparam int WAKE_CYCLES = (WAKE_TIME_US * 1000) / CLK_PERIOD_NS;

  // Line-rate dividers: ref_clk cycles per line bit at S100, S200, S400
  localparam logic [3:0] DIV_S100 = 4'h4;
  localparam logic [3:0] DIV_S200 = 4'h2;
  localparam logic [3:0] DIV_S400 = 4'h1;

  // Data path geometry
  localparam int NPORTS = 2;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Speed codes
  typedef enum logic [1:0] {
    TPDP_S100,
    TPDP_S200,
    TPDP_S400
  } tpdp_speed_e;

  // Port condition codes
  typedef enum logic [1:0] {
    TPDP_PORT_DISCONNECTED,
    TPDP_PORT_DISABLED,
    TPDP_PORT_SUSPENDED,
    TPDP_PORT_ACTIVE
  } tpdp_port_e;

  // Power levels
  typedef enum logic [1:0] {
    TPDP_PWR_ON,
    TPDP_PWR_LOW,
    TPDP_PWR_SLEEP,
    TPDP_PWR_WAKE
  } tpdp_pwr_e;

  // Host power states
  typedef enum logic [1:0] {
    TPDP_HOST_D0,
    TPDP_HOST_D2,
    TPDP_HOST_D3
  } tpdp_host_e;

  // Divider reload for a speed code
  function automatic logic [3:0] tpdp_div(input tpdp_speed_e s);
    if (s == TPDP_S400) begin
      return DIV_S400;
    end else if (s == TPDP_S200) begin
      return DIV_S200;
    end
    return DIV_S100;
  endfunction

endpackage

// >>> hdl/tpdp_fifo.sv
// Byte FIFO in flip-flops with valid/ready on both sides.
// Assumes a single clock; write and read may happen in the same cycle.
module tpdp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic full;
  } tpdp_fifo_s;

  tpdp_fifo_s st, next_st;
  logic push, pop;

  // Full and empty come from the occupancy counter
  // Registered full flag keeps ready off the count adder
  assign in_ready = !st.full;
  assign out_valid = (st.count != '0);
  assign out_data = st.mem[st.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next-state for pointers and storage
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    next_st.full = (next_st.count == (AW+1)'(DEPTH));
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// >>> hdl/tpdp_ds_rx.sv
// Data-strobe receiver for one port: recovers bits from data xor strobe transitions.
// Assumes pins already passed the three-stage synchroniser in the caller.
module tpdp_ds_rx (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Synchronised line levels
  input wire logic line_data,
  input wire logic line_strobe,
  input wire logic enable,
  // Recovered byte
  output logic byte_valid,
  output logic [7:0] byte_data
);
  import tpdp_pkg::*;

  typedef struct packed {
    logic prev_clk;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic valid;
    logic [7:0] data;
  } tpdp_rx_s;

  tpdp_rx_s st, next_st;
  logic rclk;

  // Recovered clock toggles once per bit
  assign rclk = line_data ^ line_strobe;
  assign byte_valid = st.valid;
  assign byte_data = st.data;

  // Shift a bit on every recovered-clock change, msb first
  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    next_st.prev_clk = rclk;
    if (!enable) begin
      next_st.cnt = '0;
      next_st.prev_clk = 1'b0;
    end else if (rclk != st.prev_clk) begin
      next_st.shift = {st.shift[6:0], line_data};
      next_st.cnt = st.cnt + 1'b1;
      if (st.cnt == BIT_LAST) begin
        next_st.valid = 1'b1;
        next_st.data = {st.shift[6:0], line_data};
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// >>> test/tpdp_phy_assertions.sv
// Port checks on the cable PHY core, bound into every tpdp_phy.
// Assumes one clock domain and WAKE_COUNT handed on by the bind.
module tpdp_phy_assertions #(
  parameter int WAKE_COUNT = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Line enables and receive pulse
  input wire logic [1:0] cable_pair_a_oe,
  input wire logic [1:0] cable_pair_b_oe,
  input wire logic rx_valid,
  // Port condition and speed
  input wire logic [1:0] port_receiving,
  input wire logic [1:0] port_connected,
  input wire logic [1:0] port_disabled,
  input wire logic [1:0] port_suspended,
  input wire logic [1:0] speed_sense,
  input wire tpdp_pkg::tpdp_speed_e next_speed,
  // Power management
  input wire tpdp_pkg::tpdp_host_e host_state,
  input wire logic link_power_status_bit,
  input wire logic port_int_enable,
  input wire logic clock_gen_enable,
  input wire logic sleep_deep,
  input wire logic phy_operative,
  input wire logic [1:0] port_event
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpdp_pkg::*;
  localparam int WAKE_MAX = WAKE_COUNT + 8;
  logic deep_ok;
  logic low_ok;
  // Sleep causes; held stable by the bench, so one edge of lag is harmless
  assign deep_ok = !port_int_enable && (~port_connected | port_disabled) == 2'h3;
  assign low_ok = host_state != TPDP_HOST_D0 &&
    (~port_connected | port_disabled | port_suspended) == 2'h3;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  chk_rx_quiet: assert property (
    (port_receiving & $past(port_receiving) & (cable_pair_a_oe | cable_pair_b_oe)) == 2'h0)
    else $error("transmitter on at a receiving port");
  chk_pair_same: assert property (cable_pair_a_oe == cable_pair_b_oe)
    else $error("pair enables differ");
  chk_speed_top: assert property (
    (speed_sense == 2'h3) [*6] |-> next_speed == TPDP_S400)
    else $error("fast sense not taken");
  chk_speed_low: assert property (
    (speed_sense == 2'h0) [*6] |-> next_speed == TPDP_S100)
    else $error("slow sense not taken");
  chk_deep_cause: assert property ($rose(sleep_deep) |-> $past(deep_ok))
    else $error("deep sleep without cause");
  chk_low_cause: assert property ($fell(clock_gen_enable) |-> $past(low_ok))
    else $error("low power without cause");
  chk_wake_time: assert property (
    $rose(link_power_status_bit) && !clock_gen_enable |->
    ##[1:WAKE_MAX] (clock_gen_enable && phy_operative))
    else $error("wake too slow");
  chk_event_awake: assert property (
    port_event != 2'h0 |-> phy_operative && clock_gen_enable)
    else $error("event while asleep");
  chk_low_quiet: assert property (
    !clock_gen_enable |-> (cable_pair_a_oe | cable_pair_b_oe) == 2'h0)
    else $error("driving with clocks off");
  chk_deep_off: assert property (sleep_deep |-> !clock_gen_enable)
    else $error("deep sleep with clocks on");
  chk_rx_single: assert property (rx_valid |=> !rx_valid)
    else $error("receive pulse too long");
endmodule

bind tpdp_phy tpdp_phy_assertions #(.WAKE_COUNT(WAKE_COUNT)) u_chk (
  .ref_clk, .reset, .cable_pair_a_oe, .cable_pair_b_oe, .rx_valid, .port_receiving,
  .port_connected, .port_disabled, .port_suspended, .speed_sense, .next_speed,
  .host_state, .link_power_status_bit, .port_int_enable, .clock_gen_enable,
  .sleep_deep, .phy_operative, .port_event
);

// >>> test/tpdp_remote.sv
// Remote cable node: sends data-strobe bytes and decodes the local transmitter.
// Assumes its lines reach the PHY pair inputs directly.
module tpdp_remote (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Byte to send, cycles per bit
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic [3:0] cyc,
  output logic busy,
  output logic line_data,
  output logic line_strobe,
  // Local transmitter as seen on the cable
  input wire logic seen_data,
  input wire logic seen_strobe,
  input wire logic seen_oe,
  output logic got_valid,
  output logic [7:0] got_byte,
  output logic [3:0] gap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;
  logic [3:0] nbit;
  logic [3:0] cnt;
  logic [2:0] rxn;
  logic last_x;
  logic [3:0] run;
  // Data on their pair A, strobe on pair B
  // Idle swings both lines so the xor never moves between frames
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
      line_data <= 1'b0;
      line_strobe <= 1'b0;
      nbit <= 4'h0;
      cnt <= 4'h0;
      sh <= 8'h00;
    end else if (!busy) begin
      line_data <= ~line_data;
      line_strobe <= ~line_strobe;
      busy <= send;
      sh <= send_byte;
      nbit <= 4'h8;
      cnt <= 4'h0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (nbit == 4'h0) begin
      busy <= 1'b0;
    end else begin
      // A repeated bit moves strobe, a new bit moves data
      if (sh[7] == line_data) begin
        line_strobe <= ~line_strobe;
      end else begin
        line_data <= sh[7];
      end
      sh <= {sh[6:0], 1'b0};
      nbit <= nbit - 4'h1;
      cnt <= cyc - 4'h1;
    end
  end
  // Each xor change is one bit, msb first; gap is the spacing of the last two
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      last_x <= 1'b0;
      rxn <= 3'h0;
      got_valid <= 1'b0;
      got_byte <= 8'h00;
      run <= 4'h0;
      gap <= 4'h0;
    end else begin
      got_valid <= 1'b0;
      run <= run + 4'h1;
      last_x <= seen_data ^ seen_strobe;
      if (seen_oe && (seen_data ^ seen_strobe) != last_x) begin
        got_byte <= {got_byte[6:0], seen_data};
        rxn <= rxn + 3'h1;
        run <= 4'h1;
        gap <= run;
        got_valid <= rxn == 3'h7;
      end
    end
  end
endmodule

// >>> test/tb_two_port_ds_phy_power_ctrl.sv
// Bench for the two-port cable PHY core: byte paths, coding, speeds, power.
// Assumes the remote node model and the bound checker compile alongside.
module tb_two_port_ds_phy_power_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import tpdp_pkg::*;
  localparam int WK = 16;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic tx_valid = 1'b0;
  logic [7:0] tx_data = 8'h00;
  tpdp_speed_e tx_speed = TPDP_S100;
  tpdp_speed_e next_speed;
  tpdp_host_e host_state = TPDP_HOST_D0;
  logic [1:0] port_receiving = 2'h0;
  logic [1:0] port_connected = 2'h3;
  logic [1:0] port_disabled = 2'h0;
  logic [1:0] port_suspended = 2'h0;
  logic [1:0] bias_detect = 2'h0;
  logic [1:0] speed_sense = 2'h0;
  logic link_power_status_bit = 1'b0;
  logic port_int_enable = 1'b0;
  logic send = 1'b0;
  logic [7:0] send_byte = 8'h00;
  logic [3:0] cyc = 4'h1;
  logic [31:0] rnd = 32'h824c6cb8;
  logic tx_ready, rx_valid, clock_gen_enable, sleep_deep, phy_operative, bias_en;
  logic busy, line_data, line_strobe, got_valid;
  logic [7:0] rx_data, got_byte;
  logic [3:0] gap;
  logic [1:0] a_out, a_oe, b_out, b_oe, port_event;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int checks = 0;

  tpdp_phy #(.WAKE_COUNT(WK)) dut (
    .ref_clk, .reset, .tx_valid, .tx_data, .tx_speed, .tx_ready, .rx_valid, .rx_data,
    .next_speed, .cable_pair_a_in({2{line_data}}), .cable_pair_a_out(a_out),
    .cable_pair_a_oe(a_oe), .cable_pair_b_in({2{line_strobe}}), .cable_pair_b_out(b_out),
    .cable_pair_b_oe(b_oe), .port_receiving, .port_connected, .port_disabled,
    .port_suspended, .bias_detect, .speed_sense, .host_state, .link_power_status_bit,
    .port_int_enable, .clock_gen_enable, .sleep_deep, .phy_operative,
    .cable_bias_output_en(bias_en), .port_event);
  // Far node watches port 1: data on B, strobe on A
  tpdp_remote far (.ref_clk, .reset, .send, .send_byte, .cyc, .busy, .line_data,
    .line_strobe, .seen_data(b_out[1]), .seen_strobe(a_out[1]), .seen_oe(b_oe[1]),
    .got_valid, .got_byte, .gap);

  // Clock at 8 ns
  always #4 ref_clk = ~ref_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic conclude();
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // Holds the byte until an edge with ready high, giving up after 8 edges; valid stays up for the caller
  task automatic push(input logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    tx_valid = 1'b1;
    tx_data = b;
    while (ok !== 1'b1 && n < 8) begin
      // Ready read off the edge; it stands through the edge that takes the byte
      ok = tx_ready;
      @(posedge ref_clk);
      n++;
      @(negedge ref_clk);
    end
  endtask

  task automatic drain(input logic [3:0] dv);
    int n;
    while (exp_q.size() > 0) begin
      n = 0;
      while (got_valid !== 1'b1 && n < 400) begin
        @(negedge ref_clk);
        n++;
      end
      if (n == 400) chk(8'h00, 8'h01);
      if (n == 400) conclude();
      chk(got_byte, exp_q.pop_front());
      chk(8'(gap), 8'(dv));
      @(negedge ref_clk);
    end
  endtask

  // Idle ports under a host state, then a wake of kind wk (3 means none)
  task automatic pwr(input tpdp_host_e h, input logic [1:0] c, input logic [1:0] d,
      input logic [1:0] s, input logic ie, input logic deep, input int wk);
    int n;
    host_state = h;
    port_connected = c;
    port_disabled = d;
    port_suspended = s;
    port_int_enable = ie;
    repeat (30) @(negedge ref_clk);
    chk(8'(clock_gen_enable), 8'(h == TPDP_HOST_D0));
    chk(8'(sleep_deep), 8'(deep));
    chk(8'(bias_en), 8'(!deep));
    if (wk == 0) link_power_status_bit = 1'b1;
    if (wk == 1) bias_detect = 2'h2;
    if (wk == 2) port_connected = 2'h1;
    n = 0;
    while (wk < 3 && (phy_operative & clock_gen_enable) !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    if (wk < 3) chk(8'(n >= WK && n <= WK + 8), 8'h01);
    n = 0;
    while (wk % 3 != 0 && port_event === 2'h0 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (wk % 3 != 0) chk(8'(port_event), wk == 1 ? 8'h02 : 8'h01);
    host_state = TPDP_HOST_D0;
    link_power_status_bit = 1'b0;
    bias_detect = 2'h0;
    @(negedge ref_clk);
  endtask

  initial begin
    int k;
    int n;
    logic ok;
    repeat (10) @(negedge ref_clk);
    reset = 1'b0;
    // Every sense code
    for (int v = 0; v < 4; v++) begin
      speed_sense = 2'(v);
      repeat (8) @(negedge ref_clk);
      chk(8'(next_speed), v == 3 ? 8'h02 : v != 0 ? 8'h01 : 8'h00);
    end
    // Fill while port 0 receives so nothing drains, then drain at each speed
    for (int s = 0; s < 3; s++) begin
      tx_speed = tpdp_speed_e'(s);
      port_receiving = 2'h1;
      @(negedge ref_clk);
      k = 0;
      ok = 1'b1;
      while (ok === 1'b1 && k < (s == 0 ? 40 : 3)) begin
        rnd = lfsr(rnd);
        push(rnd[7:0], ok);
        if (ok === 1'b1) exp_q.push_back(rnd[7:0]);
        if (ok === 1'b1) k++;
      end
      tx_valid = 1'b0;
      if (s == 0) chk(8'(k), 8'd32);
      port_receiving = 2'h0;
      drain(s == 0 ? DIV_S100 : s == 1 ? DIV_S200 : DIV_S400);
    end
    // Far node bytes on port 0 at three paces, repeated onto port 1
    port_receiving = 2'h1;
    for (int i = 0; i < 3; i++) begin
      n = 0;
      while (busy !== 1'b0 && n < 50) begin
        @(negedge ref_clk);
        n++;
      end
      if (n == 50) chk(8'h00, 8'h01);
      rnd = lfsr(rnd);
      send_byte = rnd[7:0];
      cyc = 4'(i + 1);
      send = 1'b1;
      @(negedge ref_clk);
      send = 1'b0;
      exp_q.push_back(rnd[7:0]);
      n = 0;
      while (rx_valid !== 1'b1 && n < 200) begin
        @(negedge ref_clk);
        n++;
      end
      if (n == 200) chk(8'h00, 8'h01);
      chk(rx_data, rnd[7:0]);
      // Sense still reads S400, so the repeat goes out at that pace
      drain(DIV_S400);
    end
    port_receiving = 2'h0;
    pwr(TPDP_HOST_D0, 2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 3);
    pwr(TPDP_HOST_D3, 2'h1, 2'h1, 2'h0, 1'b0, 1'b1, 0);
    pwr(TPDP_HOST_D2, 2'h2, 2'h0, 2'h2, 1'b0, 1'b0, 1);
    pwr(TPDP_HOST_D3, 2'h0, 2'h0, 2'h0, 1'b1, 1'b0, 2);
    conclude();
  end
endmodule
